// >>> src/asr_receiver.v
// Asynchronous serial receiver with a two-entry FIFO behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "asr_defs.vh"

module asr_receiver (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire receive_pin,
  output reg irq,
  output reg rx_int_request
);

  // Receiver states.
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  // Software registers.
  reg [7:0] baud_control_reg;
  reg [7:0] rx_ctrl_reg;
  reg [7:0] div_low_reg;
  reg [7:0] div_high_reg;
  reg [7:0] tx_ctrl_reg;
  reg receive_interrupt_enable_reg;
  reg gie_reg;
  reg peripheral_interrupt_enable_reg;
  reg [2:0] event_status_reg;
  reg [2:0] event_mask_reg;
  reg overrun_reg;

  // Pin synchroniser and edge history.
  reg pin_meta_reg;
  reg pin_sync_reg;
  reg pin_prev_reg;

  // Baud generator.
  reg [15:0] brg_cnt_reg;
  reg [1:0] pre_cnt_reg;
  reg samp_tick_reg;

  // Receive engine; the shift register is internal only.
  reg [1:0] state_reg;
  reg [3:0] tick_cnt_reg;
  reg [3:0] bit_cnt_reg;
  reg [8:0] shift_reg;
  reg vote_a_reg;
  reg vote_b_reg;
  reg push_reg;
  reg [9:0] push_data_reg;

  // FIFO of {framing error, ninth bit, data byte}; not mapped on the bus.
  reg [9:0] fifo_mem [0:1];
  reg rd_ptr_reg;
  reg [1:0] count_reg;

  // Derived control.
  wire rx_enable;
  wire wide_div;
  wire slow_rate;
  wire [15:0] divisor;
  wire bit_value;
  wire nine_bits;
  wire [3:0] last_bit;
  wire receive_interrupt_flag;
  wire wr_go;
  wire rd_go;
  wire pop;
  wire push_ok;
  wire [9:0] head;
  wire wr_idx;
  wire [7:0] wbyte;

  // Reception runs only with port on, async mode and continuous enable.
  // enable qualification
  assign rx_enable = rx_ctrl_reg[`ASR_RS_SERIAL_PORT_ENABLE] & rx_ctrl_reg[`ASR_RS_CONTINUOUS_RECEIVE_ENABLE]
                     & ~tx_ctrl_reg[`ASR_TS_SYNC];

  assign wide_div = baud_control_reg[`ASR_BC_WIDE];
  assign divisor = wide_div ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};
  // Only the 8-bit low-speed async mode gives a bit of 64 (n+1) clocks.
  assign slow_rate = ~wide_div & ~tx_ctrl_reg[`ASR_TS_HIGH];

  // Majority of three samples around the bit centre.
  assign bit_value = (vote_a_reg & vote_b_reg) | (vote_a_reg & pin_sync_reg)
                     | (vote_b_reg & pin_sync_reg);
  assign nine_bits = rx_ctrl_reg[`ASR_RS_NINE];
  assign last_bit = nine_bits ? 4'h8 : 4'h7;

  assign receive_interrupt_flag = rx_enable & (count_reg != 2'b00);

  assign head = fifo_mem[rd_ptr_reg];
  assign wr_idx = rd_ptr_reg ^ count_reg[0];
  assign wbyte = s_axi_wdata[7:0];

  // Write is taken once both address and data are offered.
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  assign pop = rd_go & (s_axi_araddr == `ASR_OFF_RX_DATA) & (count_reg != 2'b00);

  assign push_ok = push_reg & ((count_reg != 2'b10) | pop);

  // Two-flop synchroniser; only the second flop feeds logic.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= receive_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Baud generator: divisor counts n+1 clocks, slow mode adds a divide by four.
  // sixteen times oversampling tick
  always @(posedge aclk) begin
    if (!aresetn || !rx_enable) begin
      brg_cnt_reg <= 16'h0000;
      pre_cnt_reg <= 2'b00;
      samp_tick_reg <= 1'b0;
    end else if (brg_cnt_reg == 16'h0000) begin
      brg_cnt_reg <= divisor;
      if (!slow_rate || pre_cnt_reg == `ASR_SLOW_PRESCALE) begin
        pre_cnt_reg <= 2'b00;
        samp_tick_reg <= 1'b1;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 2'b01;
        samp_tick_reg <= 1'b0;
      end
    end else begin
      brg_cnt_reg <= brg_cnt_reg - 16'h0001;
      samp_tick_reg <= 1'b0;
    end
  end

  // Receive engine. The tick counter runs 0..15 per bit, so one bit is 16 ticks.
  always @(posedge aclk) begin
    if (!aresetn || !rx_enable) begin
      state_reg <= ST_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      vote_a_reg <= 1'b1;
      vote_b_reg <= 1'b1;
      push_reg <= 1'b0;
      push_data_reg <= 10'h000;
    end else begin
      push_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (!overrun_reg && pin_prev_reg && !pin_sync_reg) begin
            state_reg <= ST_START;
            tick_cnt_reg <= 4'h0;
          end
        end
        ST_START: begin
          if (samp_tick_reg) begin
            if (tick_cnt_reg == `ASR_HALF_TICK) begin
              tick_cnt_reg <= 4'h0;
              bit_cnt_reg <= 4'h0;
              if (pin_sync_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg <= ST_DATA;
              end
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
          end
        end
        ST_DATA, ST_STOP: begin
          if (samp_tick_reg) begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
            if (tick_cnt_reg == `ASR_VOTE_A) begin
              vote_a_reg <= pin_sync_reg;
            end
            if (tick_cnt_reg == `ASR_VOTE_B) begin
              vote_b_reg <= pin_sync_reg;
            end
            if (tick_cnt_reg == `ASR_VOTE_C && state_reg == ST_DATA) begin
              shift_reg <= {bit_value, shift_reg[8:1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == last_bit) begin
                state_reg <= ST_STOP;
              end
            end else if (tick_cnt_reg == `ASR_VOTE_C) begin
              push_reg <= 1'b1;
              if (nine_bits) begin
                push_data_reg <= {~bit_value, shift_reg};
              end else begin
                push_data_reg <= {~bit_value, 1'b0, shift_reg[8:1]};
              end
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // FIFO storage; a pop and a push in the same cycle both happen.
  always @(posedge aclk) begin
    if (push_ok) begin
      // With two held, a same-cycle pop frees the head slot that wr_idx names.
      fifo_mem[wr_idx] <= push_data_reg;
    end
  end

  // FIFO pointers and the overrun latch, cleared with the receiver.
  always @(posedge aclk) begin
    if (!aresetn || !rx_enable) begin
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'b00;
      overrun_reg <= 1'b0;
    end else begin
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push_ok && !pop) begin
        count_reg <= count_reg + 2'b01;
      end else if (pop && !push_ok) begin
        count_reg <= count_reg - 2'b01;
      end
      if (push_reg && !push_ok) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  // Register writes, write handshake and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_control_reg <= `ASR_BC_RESET;
      rx_ctrl_reg <= `ASR_RS_RESET;
      tx_ctrl_reg <= `ASR_TS_RESET;
      div_low_reg <= `ASR_DIV_RESET;
      div_high_reg <= `ASR_DIV_RESET;
      receive_interrupt_enable_reg <= 1'b0;
      gie_reg <= 1'b0;
      peripheral_interrupt_enable_reg <= 1'b0;
      event_mask_reg <= 3'b000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASR_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ASR_RESP_OKAY;
        // Only byte lane 0 carries data; other lanes are ignored.
        if (s_axi_wstrb[0]) begin
          case (s_axi_awaddr)
            `ASR_OFF_BAUD_CONTROL: begin
              baud_control_reg <= wbyte & `ASR_BC_WMASK;
            end
            `ASR_OFF_RX_STATUS_CONTROL: begin
              rx_ctrl_reg <= wbyte & `ASR_RS_WMASK;
            end
            `ASR_OFF_DIVISOR_LOW: begin
              div_low_reg <= wbyte;
            end
            `ASR_OFF_DIVISOR_HIGH: begin
              div_high_reg <= wbyte;
            end
            `ASR_OFF_TX_STATUS_CONTROL: begin
              tx_ctrl_reg <= wbyte & `ASR_TS_WMASK;
            end
            `ASR_OFF_ENABLE_ONE: begin
              receive_interrupt_enable_reg <= wbyte[`ASR_EN_RECEIVE_INTERRUPT_ENABLE];
            end
            `ASR_OFF_INT_CONTROL: begin
              gie_reg <= wbyte[`ASR_IC_GIE];
              peripheral_interrupt_enable_reg <= wbyte[`ASR_IC_PERIPHERAL_INTERRUPT_ENABLE];
            end
            `ASR_OFF_EVENT_MASK: begin
              event_mask_reg <= wbyte[2:0];
            end
            // Read-only and clear-by-one registers are handled elsewhere.
            `ASR_OFF_RX_DATA, `ASR_OFF_FLAG_ONE, `ASR_OFF_EVENT_STATUS: begin
            end
            default: begin
              s_axi_bresp <= `ASR_RESP_SLVERR;
            end
          endcase
        end else if (s_axi_awaddr > `ASR_OFF_EVENT_MASK || s_axi_awaddr[1:0] != 2'b00) begin
          s_axi_bresp <= `ASR_RESP_SLVERR;
        end
      end
    end
  end

  // Sticky event bits: set wins over a write-one-to-clear in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_status_reg <= 3'b000;
    end else begin
      if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `ASR_OFF_EVENT_STATUS) begin
        event_status_reg <= event_status_reg & ~wbyte[2:0];
      end
      if (push_ok) begin
        event_status_reg[`ASR_EV_CHAR] <= 1'b1;
      end
      if (push_ok && push_data_reg[9]) begin
        event_status_reg[`ASR_EV_FRAME] <= 1'b1;
      end
      if (push_reg && !push_ok) begin
        event_status_reg[`ASR_EV_OVR] <= 1'b1;
      end
    end
  end

  // Read channel; the FIFO data byte is only reachable through the data register.
  // no direct FIFO access
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ASR_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ASR_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `ASR_OFF_BAUD_CONTROL: begin
            s_axi_rdata[7:0] <= baud_control_reg;
            s_axi_rdata[`ASR_BC_IDLE] <= (state_reg == ST_IDLE);
          end
          `ASR_OFF_RX_STATUS_CONTROL: begin
            // Framing and ninth bit describe the oldest unread character.
            s_axi_rdata[7:0] <= rx_ctrl_reg;
            s_axi_rdata[`ASR_RS_FRAMING_ERROR] <= (count_reg != 2'b00) & head[9];
            s_axi_rdata[`ASR_RS_OVERRUN_ERROR] <= overrun_reg;
            s_axi_rdata[`ASR_RS_NINTH] <= (count_reg != 2'b00) & head[8];
          end
          `ASR_OFF_DIVISOR_LOW: begin
            s_axi_rdata[7:0] <= div_low_reg;
          end
          `ASR_OFF_DIVISOR_HIGH: begin
            s_axi_rdata[7:0] <= div_high_reg;
          end
          `ASR_OFF_TX_STATUS_CONTROL: begin
            // No transmitter here, so its shift register always reads empty.
            s_axi_rdata[7:0] <= tx_ctrl_reg;
            s_axi_rdata[`ASR_TS_EMPTY] <= 1'b1;
          end
          `ASR_OFF_RX_DATA: begin
            if (count_reg != 2'b00) begin
              s_axi_rdata[7:0] <= head[7:0];
            end
          end
          `ASR_OFF_FLAG_ONE: begin
            s_axi_rdata[`ASR_FLAG_RECEIVE_INTERRUPT_FLAG] <= receive_interrupt_flag;
          end
          `ASR_OFF_ENABLE_ONE: begin
            s_axi_rdata[`ASR_EN_RECEIVE_INTERRUPT_ENABLE] <= receive_interrupt_enable_reg;
          end
          `ASR_OFF_INT_CONTROL: begin
            s_axi_rdata[`ASR_IC_GIE] <= gie_reg;
            s_axi_rdata[`ASR_IC_PERIPHERAL_INTERRUPT_ENABLE] <= peripheral_interrupt_enable_reg;
          end
          `ASR_OFF_EVENT_STATUS: begin
            s_axi_rdata[2:0] <= event_status_reg;
          end
          `ASR_OFF_EVENT_MASK: begin
            s_axi_rdata[2:0] <= event_mask_reg;
          end
          default: begin
            s_axi_rresp <= `ASR_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Interrupt outputs, both registered so they never glitch.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      rx_int_request <= 1'b0;
    end else begin
      irq <= |(event_status_reg & event_mask_reg);
      rx_int_request <= receive_interrupt_flag & receive_interrupt_enable_reg & peripheral_interrupt_enable_reg & gie_reg;
    end
  end

endmodule

// >>> src/asr_defs.vh
// Constants for the asynchronous serial receiver: offsets, bit positions, resets, timing.
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define ASR_OFF_BAUD_CONTROL 8'h00
`define ASR_OFF_RX_STATUS_CONTROL 8'h04
`define ASR_OFF_DIVISOR_LOW 8'h08
`define ASR_OFF_DIVISOR_HIGH 8'h0C
`define ASR_OFF_TX_STATUS_CONTROL 8'h10
`define ASR_OFF_RX_DATA 8'h14
`define ASR_OFF_FLAG_ONE 8'h18
`define ASR_OFF_ENABLE_ONE 8'h1C
`define ASR_OFF_INT_CONTROL 8'h20
`define ASR_OFF_EVENT_STATUS 8'h24
`define ASR_OFF_EVENT_MASK 8'h28

// Baud control bit positions.
`define ASR_BC_IDLE 6
`define ASR_BC_WIDE 3
// Receive status and control bit positions.
`define ASR_RS_SERIAL_PORT_ENABLE 7
`define ASR_RS_NINE 6
`define ASR_RS_CONTINUOUS_RECEIVE_ENABLE 4
`define ASR_RS_FRAMING_ERROR 2
`define ASR_RS_OVERRUN_ERROR 1
`define ASR_RS_NINTH 0
// Transmit status and control bit positions.
`define ASR_TS_SYNC 4
`define ASR_TS_HIGH 2
`define ASR_TS_EMPTY 1
// Interrupt bits.
`define ASR_FLAG_RECEIVE_INTERRUPT_FLAG 0
`define ASR_EN_RECEIVE_INTERRUPT_ENABLE 0
`define ASR_IC_GIE 7
`define ASR_IC_PERIPHERAL_INTERRUPT_ENABLE 6
`define ASR_EV_CHAR 0
`define ASR_EV_FRAME 1
`define ASR_EV_OVR 2

// Writable masks and reset values.
`define ASR_BC_WMASK 8'h1B
`define ASR_RS_WMASK 8'hF8
`define ASR_TS_WMASK 8'hFD
`define ASR_BC_RESET 8'h00
`define ASR_RS_RESET 8'h00
`define ASR_TS_RESET 8'h00
`define ASR_DIV_RESET 8'h00

// Timing: oversampling ratio, half bit point and vote ticks.
`define ASR_OVERSAMPLE 16
`define ASR_HALF_TICK 4'h7
`define ASR_VOTE_A 4'hD
`define ASR_VOTE_B 4'hE
`define ASR_VOTE_C 4'hF
`define ASR_SLOW_PRESCALE 2'h3

// AXI responses.
`define ASR_RESP_OKAY 2'b00
`define ASR_RESP_SLVERR 2'b10

`endif

// >>> bench/asr_rx_asserts.sv
// Concurrent checks on the receiver's bus ports, with covers on its interrupt ports.
`timescale 1ns/1ps
module asr_rx_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq,
  input wire rx_int_request
);
  // Every check uses the bus clock and is muted while reset is held.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A taken write is answered on the very next edge.
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
    && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write late");
  // Address and data ready pulse together, only for an offered write.
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid
    && $past(s_axi_awvalid)) else $error("ready pair broken");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  // No new write is taken while a response waits.
  a_write_busy: assert property (s_axi_bvalid |=> !s_axi_awready) else $error("write overlap");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read lost");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready long");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00
    || s_axi_bresp == 2'b10) else $error("bad write response");
  // Main scenarios reached.
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_request: cover property ($rose(rx_int_request));
  c_irq: cover property ($rose(irq));
endmodule
bind asr_receiver asr_rx_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq), .rx_int_request(rx_int_request));

// >>> bench/asr_line_model.sv
// Remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
module asr_line_model (
  output logic receive_pin,
  input wire aclk
);
  // Clocks per bit; the bench sets it to match the divisor it programs.
  int bit_clks = 16;
  // The line idles high between characters.
  // pin used as digital input
  initial receive_pin = 1'b1;
  // Drive one level for a number of clocks, starting right after an edge.
  task automatic hold(input logic v, input int n);
    receive_pin <= v;
    repeat (n) @(posedge aclk);
  endtask
  task automatic send(input [8:0] d, input int nb, input logic stop_hi);
    @(posedge aclk);
    hold(1'b0, bit_clks);
    for (int i = 0; i < nb; i++) hold(d[i], bit_clks);
    hold(stop_hi, bit_clks);
    hold(1'b1, bit_clks);
  endtask
  // A low pulse shorter than half a bit, as noise would make.
  task automatic glitch(input int n);
    @(posedge aclk);
    hold(1'b0, n);
    hold(1'b1, bit_clks);
  endtask
endmodule

// >>> bench/asr_receiver_tb.sv
// Self-checking bench for the asynchronous serial receiver.
`timescale 1ns/1ps
`include "asr_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module asr_receiver_tb;
  // Register offsets and status values used below.
  localparam [7:0] BC = `ASR_OFF_BAUD_CONTROL;
  localparam [7:0] RS = `ASR_OFF_RX_STATUS_CONTROL;
  localparam [7:0] DL = `ASR_OFF_DIVISOR_LOW;
  localparam [7:0] TS = `ASR_OFF_TX_STATUS_CONTROL;
  localparam [7:0] RD = `ASR_OFF_RX_DATA;
  localparam [7:0] FL = `ASR_OFF_FLAG_ONE;
  localparam [7:0] EN = `ASR_OFF_ENABLE_ONE;
  localparam [7:0] IC = `ASR_OFF_INT_CONTROL;
  localparam [7:0] EV = `ASR_OFF_EVENT_STATUS;
  localparam [7:0] EM = `ASR_OFF_EVENT_MASK;
  localparam [31:0] RS_ON = (32'h1 << `ASR_RS_SERIAL_PORT_ENABLE) | (32'h1 << `ASR_RS_CONTINUOUS_RECEIVE_ENABLE);
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [7:0] s_axi_araddr = 8'h00;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire receive_pin, irq, rx_int_request;
  int failures = 0;
  int compares = 0;
  logic [1:0] rr;
  logic [31:0] rv;
  // 100 MHz clock.
  always #5 aclk = ~aclk;
  asr_receiver DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .receive_pin(receive_pin), .irq(irq),
    .rx_int_request(rx_int_request));
  asr_line_model u_line (.receive_pin(receive_pin), .aclk(aclk));
  // Print the counts and the verdict, then stop.
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One write; each channel is released at the edge that takes it.
  task automatic bus_wr(input [7:0] a, input [7:0] d, output [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // A response that never comes ends the run.
    if (!s_axi_bvalid) begin failures++; close_out; end
  endtask
  // One read; data and response are taken at the handshake edge.
  task automatic bus_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) begin failures++; close_out; end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    bus_wr(a, d, rr);
    `CHK("write resp", 2'b00, rr)
  endtask
  task automatic rchk(input [7:0] a, input [31:0] e, input string nm);
    bus_rd(a, rv, rr);
    `CHK("read resp", 2'b00, rr)
    `CHK(nm, e, rv)
  endtask
  // Reset values, a read-write register and an unmapped offset.
  task automatic t_regs;
    logic [7:0] offs [7] = '{BC, RS, DL, TS, EN, IC, EM};
    logic [31:0] vals [7] = '{32'h0000_0040, 32'h0, 32'h0, 32'h0000_0002, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) rchk(offs[i], vals[i], "reset value");
    wr(DL, 8'h5A);
    rchk(DL, 32'h0000_005A, "divisor");
    wr(DL, 8'h00);
    bus_rd(8'h2C, rv, rr);
    `CHK("unmapped resp", `ASR_RESP_SLVERR, rr)
  endtask
  // One character, the flag, the event interrupt and the request chain.
  task automatic t_one;
    wr(BC, 8'h01 << `ASR_BC_WIDE);
    wr(EM, 8'h01);
    wr(RS, RS_ON[7:0]);
    u_line.send(9'h0A5, 8, 1'b1);
    rchk(FL, 32'h1, "flag");
    wr(FL, 8'h00);
    rchk(FL, 32'h1, "flag kept");
    `CHK("irq", 1'b1, irq)
    wr(EN, 8'h01);
    wr(IC, 8'h40);
    rchk(EV, 32'h1, "event");
    `CHK("request", 1'b0, rx_int_request)
    wr(IC, 8'hC0);
    rchk(EV, 32'h1, "event");
    `CHK("request", 1'b1, rx_int_request)
    wr(EM, 8'h00);
    wr(EV, 8'h01);
    wr(EM, 8'h01);
    rchk(EV, 32'h0, "event cleared");
    `CHK("irq", 1'b0, irq)
    rchk(RD, 32'h0000_00A5, "data");
    rchk(FL, 32'h0, "flag");
    `CHK("request", 1'b0, rx_int_request)
  endtask
  // Noise, then a bad stop bit.
  task automatic t_frame;
    u_line.glitch(4);
    rchk(EV, 32'h0, "no event");
    u_line.send(9'h03C, 8, 1'b0);
    rchk(RS, RS_ON | (32'h1 << `ASR_RS_FRAMING_ERROR), "status");
    wr(EV, 8'h03);
    rchk(RD, 32'h0000_003C, "data");
    rchk(RS, RS_ON, "status");
  endtask
  // Three characters into a two-deep store.
  task automatic t_over;
    u_line.send(9'h011, 8, 1'b1);
    u_line.send(9'h022, 8, 1'b1);
    u_line.send(9'h033, 8, 1'b1);
    rchk(RS, RS_ON | (32'h1 << `ASR_RS_OVERRUN_ERROR), "status");
    rchk(RD, 32'h0000_0011, "data");
    rchk(RD, 32'h0000_0022, "data");
    rchk(RD, 32'h0, "empty");
    u_line.send(9'h044, 8, 1'b1);
    rchk(FL, 32'h0, "flag");
    wr(RS, 8'h80);
    wr(RS, RS_ON[7:0]);
    wr(EV, 8'h07);
    rchk(RS, RS_ON, "status");
  endtask
  // Sync mode or no continuous receive keeps the receiver off.
  task automatic t_enable;
    wr(TS, 8'h01 << `ASR_TS_SYNC);
    u_line.send(9'h055, 8, 1'b1);
    rchk(FL, 32'h0, "flag");
    wr(TS, 8'h00);
    wr(RS, 8'h80);
    u_line.send(9'h055, 8, 1'b1);
    rchk(FL, 32'h0, "flag");
    wr(RS, RS_ON[7:0]);
  endtask
  // Nine-bit character: the ninth bit shows in the status register.
  task automatic t_nine;
    wr(RS, RS_ON[7:0] | (8'h01 << `ASR_RS_NINE));
    u_line.send(9'h15A, 9, 1'b1);
    rchk(RS, RS_ON | (32'h1 << `ASR_RS_NINE) | 32'h1, "nine status");
    rchk(RD, 32'h0000_005A, "nine data");
    wr(RS, RS_ON[7:0]);
  endtask
  // Slow 8-bit rate: bit = 64 (n+1) clocks with n = 1.
  task automatic t_slow;
    wr(BC, 8'h00);
    wr(DL, 8'h01);
    u_line.bit_clks = 128;
    u_line.send(9'h0C3, 8, 1'b1);
    rchk(RD, 32'h0000_00C3, "slow data");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_one;
    t_frame;
    t_over;
    t_enable;
    t_nine;
    t_slow;
    close_out;
  end
endmodule
